// *** hdl/settle_params.svh ***
`ifndef SETTLE_PARAMS_SVH
`define SETTLE_PARAMS_SVH

`define ADDR_SETTLE_CH0 8'h10
`define ADDR_SETTLE_CH1 8'h11
`define ADDR_SETTLE_CH2 8'h12
`define ADDR_SETTLE_CH3 8'h13
`define ADDR_PRESCALERS 8'h14
`define SETTLE_RESET 16'h0000
`define PRESCALERS_RESET 16'h0000
`define SETTLE_MIN_FIELD 16'h0001
`define SETTLE_MIN_TICKS 20'h0_0020
`define SETTLE_SHIFT 4
`define TICKS_W 20
`define REF_DIV_ZERO 10'h000
`define REF_DIV_ONE 10'h001
`define REF_CNT_ZERO 10'h000
`define TICKS_ZERO 20'h0_0000
`define TICKS_ONE 20'h0_0001
`define RDATA_ZERO 16'h0000

`endif

// *** hdl/settle_pkg.sv ***
package settle_pkg;

    typedef struct packed {
        logic [3:0] sensor_input_prescale;
        logic [1:0] reserved;
        logic [9:0] reference_prescale;
    } prescalers_t;

    typedef struct packed {
        logic [3:0][15:0] interval;
        prescalers_t prescalers;
    } settle_cfg_t;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_settle = 2'b01,
        st_start = 2'b10
    } settle_state_t;

endpackage

// *** hdl/settle_regfile.sv ***
`timescale 1ns/1ns
`include "settle_params.svh"

module settle_regfile #(
    parameter bit four_channel = 1'b1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output settle_pkg::settle_cfg_t cfg
);

    logic [3:0][15:0] interval_ff;
    logic [15:0] prescalers_ff;
    logic [15:0] rdata_ff;
    logic [3:0] hit_settle;
    logic hit_prescalers;
    logic [15:0] nxt_rdata;

    // channels 2 and 3 decode only in the four-channel build
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_settle
            localparam logic [7:0] ADDR = `ADDR_SETTLE_CH0 + 8'(g);
            assign hit_settle[g] = (reg_addr == ADDR) && ((g < 2) || four_channel);
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    interval_ff[g] <= `SETTLE_RESET;
                end else if (reg_wr && hit_settle[g]) begin
                    interval_ff[g] <= reg_wdata;
                end
            end
        end
    endgenerate

    assign hit_prescalers = (reg_addr == `ADDR_PRESCALERS);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prescalers_ff <= `PRESCALERS_RESET;
        end else if (reg_wr && hit_prescalers) begin
            prescalers_ff <= reg_wdata;
        end
    end

    assign nxt_rdata = hit_settle[0] ? interval_ff[0] :
                       hit_settle[1] ? interval_ff[1] :
                       hit_settle[2] ? interval_ff[2] :
                       hit_settle[3] ? interval_ff[3] :
                       hit_prescalers ? prescalers_ff : `RDATA_ZERO;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= `RDATA_ZERO;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    // one driver for the whole config word: intervals above, divider register below
    assign cfg = {interval_ff, prescalers_ff};

    property p_settle_write;
        @(posedge clock) disable iff (!resetn)
        (reg_wr && reg_addr == `ADDR_SETTLE_CH1) |=> interval_ff[1] == $past(reg_wdata);
    endproperty
    a_settle_write: assert property (p_settle_write) else $error("settle write lost");

    property p_small_variant;
        @(posedge clock) disable iff (!resetn)
        (!four_channel && reg_rd &&
            (reg_addr == `ADDR_SETTLE_CH2 || reg_addr == `ADDR_SETTLE_CH3)) |=>
            reg_rdata == `RDATA_ZERO;
    endproperty
    a_small_variant: assert property (p_small_variant) else $error("ch3 in 2ch build");

    property p_fields;
        @(posedge clock) disable iff (!resetn)
        (reg_wr && hit_prescalers) |=>
            cfg.prescalers.reference_prescale == $past(reg_wdata[9:0]) &&
            cfg.prescalers.sensor_input_prescale == $past(reg_wdata[15:12]);
    endproperty
    a_fields: assert property (p_fields) else $error("divider field layout");

endmodule // settle_regfile

// *** hdl/sensor_settle_timing.sv ***
// What this block does
// - a conversion on a channel starts only after that channel's settling interval has elapsed.
// - a settling field of zero or one gives an interval of 32 reference clock periods.
// - a settling field of two or more gives the field times 16 reference clock periods.
// - an unsettled amplitude at conversion start raises an amplitude error only if enabled.
// - each settling register is a 16-bit read/write field that resets to zero.
// - settling registers sit at consecutive addresses, channel 0 lowest, channel 1 next.
// - settling registers for channels 2 and 3 exist only in the four-channel build.
// - the divider register holds input divider in bits 15:12, reserved 11:10, reference 9:0.
// - the reference clock is the device clock divided by the reference divider, never by zero.
`timescale 1ns/1ns
`include "settle_params.svh"

module sensor_settle_timing #(
    parameter bit four_channel = 1'b1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic conv_req,
    input wire logic [1:0] conv_chan,
    input wire logic amp_stable,
    input wire logic amp_err_en,
    output logic busy,
    output logic conv_start,
    output logic [1:0] conv_start_chan,
    output logic amp_err,
    output logic [3:0] sensor_input_prescale_ch0,
    output logic [9:0] reference_prescale_ch0
);

    settle_pkg::settle_cfg_t cfg;
    settle_pkg::settle_state_t state_ff, nxt_state;
    logic [9:0] ref_cnt_ff, nxt_ref_cnt;
    logic [`TICKS_W-1:0] ticks_ff, nxt_ticks;
    logic [`TICKS_W-1:0] target_ff;
    logic [1:0] chan_ff;
    logic amp_meta_ff, amp_sync_ff;
    logic amp_err_ff, conv_start_ff;
    logic [9:0] eff_div;
    logic ref_tick;
    logic req_take;
    logic [15:0] sel_field;
    logic settle_done;
    logic chan_ok;

    function automatic logic [`TICKS_W-1:0] settle_ticks(input logic [15:0] field);
        if (field <= `SETTLE_MIN_FIELD) begin
            settle_ticks = `SETTLE_MIN_TICKS;
        end else begin
            settle_ticks = {field, 4'h0};
        end
    endfunction

    settle_regfile #(.four_channel(four_channel)) u_regs (
        .clock(clock),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .cfg(cfg)
    );

    assign sensor_input_prescale_ch0 = cfg.prescalers.sensor_input_prescale;
    assign reference_prescale_ch0 = cfg.prescalers.reference_prescale;

    // a reserved zero divider is run as divide-by-one so the timer never hangs
    assign eff_div = (reference_prescale_ch0 == `REF_DIV_ZERO) ? `REF_DIV_ONE
                                                               : reference_prescale_ch0;
    assign ref_tick = (ref_cnt_ff >= eff_div - `REF_DIV_ONE);
    assign nxt_ref_cnt = ref_tick ? `REF_CNT_ZERO : ref_cnt_ff + `REF_DIV_ONE;

    assign chan_ok = four_channel || !conv_chan[1];
    assign req_take = conv_req && chan_ok && (state_ff == settle_pkg::st_idle);
    assign sel_field = cfg.interval[conv_chan];
    assign settle_done = (state_ff == settle_pkg::st_settle) && (ticks_ff >= target_ff);

    always_comb begin
        nxt_state = state_ff;
        nxt_ticks = ticks_ff;
        unique case (state_ff)
            settle_pkg::st_idle: begin
                nxt_ticks = `TICKS_ZERO;
                if (req_take) begin
                    nxt_state = settle_pkg::st_settle;
                end
            end
            settle_pkg::st_settle: begin
                if (settle_done) begin
                    nxt_state = settle_pkg::st_start;
                end else if (ref_tick) begin
                    nxt_ticks = ticks_ff + `TICKS_ONE;
                end
            end
            settle_pkg::st_start: begin
                nxt_state = settle_pkg::st_idle;
            end
            default: begin
                nxt_state = settle_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff <= settle_pkg::st_idle;
            ticks_ff <= `TICKS_ZERO;
            ref_cnt_ff <= `REF_CNT_ZERO;
        end else begin
            state_ff <= nxt_state;
            ticks_ff <= nxt_ticks;
            ref_cnt_ff <= nxt_ref_cnt;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            target_ff <= `SETTLE_MIN_TICKS;
            chan_ff <= 2'h0;
        end else if (req_take) begin
            target_ff <= settle_ticks(sel_field);
            chan_ff <= conv_chan;
        end
    end

    // amplitude detector is analog, so synchronise before use
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            amp_meta_ff <= 1'b0;
            amp_sync_ff <= 1'b0;
        end else begin
            amp_meta_ff <= amp_stable;
            amp_sync_ff <= amp_meta_ff;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            conv_start_ff <= 1'b0;
            amp_err_ff <= 1'b0;
        end else begin
            conv_start_ff <= settle_done;
            amp_err_ff <= settle_done && !amp_sync_ff && amp_err_en;
        end
    end

    assign conv_start = conv_start_ff;
    assign conv_start_chan = chan_ff;
    assign amp_err = amp_err_ff;
    assign busy = (state_ff != settle_pkg::st_idle);

    // helper: cycles between reference ticks
    logic [9:0] gap_ff;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            gap_ff <= `REF_CNT_ZERO;
        end else begin
            gap_ff <= ref_tick ? `REF_CNT_ZERO : gap_ff + `REF_DIV_ONE;
        end
    end

    property p_small_field;
        @(posedge clock) disable iff (!resetn)
        (req_take && sel_field <= `SETTLE_MIN_FIELD) |=> target_ff == `SETTLE_MIN_TICKS;
    endproperty
    a_small_field: assert property (p_small_field) else $error("short settle not 32");

    property p_large_field;
        @(posedge clock) disable iff (!resetn)
        (req_take && sel_field > `SETTLE_MIN_FIELD) |=>
            target_ff == ($past(sel_field) << `SETTLE_SHIFT);
    endproperty
    a_large_field: assert property (p_large_field) else $error("settle not field x16");

    property p_start_after_settle;
        @(posedge clock) disable iff (!resetn)
        conv_start |-> $past(ticks_ff) >= $past(target_ff) &&
                       $past(state_ff) == settle_pkg::st_settle;
    endproperty
    a_start_after_settle: assert property (p_start_after_settle) else $error("early start");

    property p_start_once;
        @(posedge clock) disable iff (!resetn)
        req_take |=> !conv_start ##1 busy [*2];
    endproperty
    a_start_once: assert property (p_start_once) else $error("start without settle");

    property p_amp_err_raise;
        @(posedge clock) disable iff (!resetn)
        (settle_done && !amp_sync_ff && amp_err_en) |=> amp_err && conv_start;
    endproperty
    a_amp_err_raise: assert property (p_amp_err_raise) else $error("amp error missed");

    property p_amp_err_gate;
        @(posedge clock) disable iff (!resetn)
        amp_err |-> $past(amp_err_en) && !$past(amp_sync_ff) && conv_start;
    endproperty
    a_amp_err_gate: assert property (p_amp_err_gate) else $error("spurious amp error");

    property p_tick_spacing;
        @(posedge clock) disable iff (!resetn)
        (ref_tick && $stable(eff_div) && $past(ref_tick)) |-> eff_div == `REF_DIV_ONE;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("ref tick too fast");

    property p_tick_period;
        @(posedge clock) disable iff (!resetn)
        (ref_tick && $stable(eff_div)) |-> gap_ff == eff_div - `REF_DIV_ONE
                                            || $past(ref_cnt_ff) >= eff_div;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("ref period wrong");

    c_settle_done: cover property (@(posedge clock) disable iff (!resetn) conv_start);
    c_amp_err: cover property (@(posedge clock) disable iff (!resetn) amp_err);
    c_long_field: cover property (@(posedge clock) disable iff (!resetn)
        req_take && sel_field > `SETTLE_MIN_FIELD);

endmodule // sensor_settle_timing

// *** verification/lc_sensor_model.sv ***
`timescale 1ns/1ns
module lc_sensor_model (
    input wire logic clock,
    input wire logic excited,
    input wire logic [15:0] settle_delay,
    output logic amp_stable
);
    logic [15:0] age_ff;
    // amplitude builds up only while the drive runs, and collapses when it stops
    always_ff @(posedge clock) begin
        if (!excited) begin
            age_ff <= 16'h0000;
        end else if (age_ff != 16'hffff) begin
            age_ff <= age_ff + 16'h0001;
        end
    end
    assign amp_stable = excited && (age_ff >= settle_delay);
endmodule // lc_sensor_model

// *** verification/test_sensor_settle_timing.sv ***
`timescale 1ns/1ns
module test_sensor_settle_timing;
    typedef struct packed {
        logic [15:0] field;
        logic [9:0] div;
        logic [1:0] chan;
        logic [15:0] ticks;
    } row_t;
    logic clock, resetn, reg_wr, reg_rd, conv_req, amp_stable, amp_err_en;
    logic busy, busy2, conv_start, amp_err;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rdata2, settle_delay, v;
    logic [1:0] conv_chan, conv_start_chan;
    logic [3:0] in_div;
    logic [9:0] ref_div;
    int miscompares = 0;
    int check_count = 0;
    row_t rows [6] = '{
        '{16'h0000, 10'h001, 2'h0, 16'h0020},
        '{16'h0001, 10'h001, 2'h1, 16'h0020},
        '{16'h0002, 10'h001, 2'h2, 16'h0020},
        '{16'h0003, 10'h001, 2'h3, 16'h0030},
        '{16'h0100, 10'h001, 2'h0, 16'h1000},
        '{16'h0005, 10'h003, 2'h1, 16'h0050}};

    sensor_settle_timing DUT (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conv_req(conv_req), .conv_chan(conv_chan), .amp_stable(amp_stable),
        .amp_err_en(amp_err_en), .busy(busy), .conv_start(conv_start),
        .conv_start_chan(conv_start_chan), .amp_err(amp_err),
        .sensor_input_prescale_ch0(in_div), .reference_prescale_ch0(ref_div));
    sensor_settle_timing #(.four_channel(1'b0)) dut_two_channel (.clock(clock),
        .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(rdata2), .conv_req(conv_req), .conv_chan(conv_chan),
        .amp_stable(amp_stable), .amp_err_en(amp_err_en), .busy(busy2), .conv_start(),
        .conv_start_chan(), .amp_err(), .sensor_input_prescale_ch0(),
        .reference_prescale_ch0());
    lc_sensor_model sensor (.clock(clock), .excited(busy), .settle_delay(settle_delay),
        .amp_stable(amp_stable));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic stop_test;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // poke sends a second request while busy, which must be ignored
    // t ticks of d clocks: the free-running reference phase puts the start
    // between (t-1)*d+2 and t*d+1 edges after the take
    task automatic conv(input logic [1:0] ch, input int t, input int d,
                        input logic err, input logic poke);
        int n;
        int lo;
        int hi;
        n = 0;
        lo = (t - 1) * d + 2;
        hi = t * d + 1;
        @(posedge clock);
        conv_req <= 1'b1;
        conv_chan <= ch;
        @(posedge clock);
        conv_req <= 1'b0;
        while (n < 20000) begin
            @(posedge clock);
            n++;
            if (poke && n == 3) begin
                conv_req <= 1'b1;
                conv_chan <= ~ch;
            end
            if (n == 4) conv_req <= 1'b0;
            #1;
            if (n == 2) chk("busy", busy, 1'b1);
            if (n == 2) chk("busy_two", busy2, !ch[1]);
            if (conv_start === 1'b1) break;
        end
        if (n >= 20000) begin
            miscompares++;
            stop_test();
        end
        chk("start_window", (n >= lo && n <= hi), 1'b1);
        chk("amp_err", amp_err, err);
        chk("start_chan", conv_start_chan, ch);
        @(posedge clock);
        #1;
        chk("busy_after", busy, 1'b0);
    endtask

    initial begin
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        conv_req = 1'b0;
        conv_chan = 2'h0;
        amp_err_en = 1'b1;
        settle_delay = 16'h0000;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        for (int a = 16; a <= 20; a++) begin
            rd(8'(a), v);
            chk("reset_value", v, 16'h0000);
        end
        for (int i = 0; i < 6; i++) begin
            wr(8'h10 + 8'(rows[i].chan), rows[i].field);
            wr(8'h14, {4'h1, 2'h0, rows[i].div});
            rd(8'h10 + 8'(rows[i].chan), v);
            chk("settle_rw", v, rows[i].field);
            conv(rows[i].chan, int'(rows[i].ticks), int'(rows[i].div), 1'b0, 1'b0);
        end
        // sensor never settles in time
        wr(8'h10, 16'h0000);
        wr(8'h14, 16'h1001);
        settle_delay <= 16'hffff;
        conv(2'h0, 32, 1, 1'b1, 1'b1);
        @(posedge clock);
        amp_err_en <= 1'b0;
        conv(2'h0, 32, 1, 1'b0, 1'b0);
        wr(8'h14, 16'h93ff);
        rd(8'h14, v);
        chk("prescalers", v, 16'h93ff);
        chk("input_div", in_div, 4'h9);
        chk("ref_div", ref_div, 10'h3ff);
        wr(8'h12, 16'h1234);
        rd(8'h12, v);
        chk("ch2_four", v, 16'h1234);
        chk("ch2_two", rdata2, 16'h0000);
        rd(8'h15, v);
        chk("unmapped", v, 16'h0000);
        wr(8'h11, 16'h0040);
        @(posedge clock);
        conv_req <= 1'b1;
        conv_chan <= 2'h1;
        @(posedge clock);
        conv_req <= 1'b0;
        repeat (5) @(posedge clock);
        #1;
        chk("busy_pre_reset", busy, 1'b1);
        @(posedge clock);
        resetn <= 1'b0;
        @(posedge clock);
        #1;
        chk("busy_reset", busy, 1'b0);
        chk("div_reset", ref_div, 10'h000);
        @(posedge clock);
        resetn <= 1'b1;
        rd(8'h11, v);
        chk("settle_reset", v, 16'h0000);
        stop_test();
    end
endmodule // test_sensor_settle_timing
